// ---- logic/porta_pkg.sv ----
// shared constants and types for the port a pull-up, change and wake block
package porta_pkg;

	// register word addresses (byte offsets, one 32-bit word each)
	localparam logic [7:0] ADR_PULLUP_EN   = 8'h00;
	localparam logic [7:0] ADR_CHANGE_EN   = 8'h04;
	localparam logic [7:0] ADR_DIRECTION   = 8'h08;
	localparam logic [7:0] ADR_OPTION      = 8'h0C;
	localparam logic [7:0] ADR_POWER_CTL   = 8'h10;
	localparam logic [7:0] ADR_INT_CTL     = 8'h14;
	localparam logic [7:0] ADR_PIN_STATE   = 8'h18;
	localparam logic [7:0] ADR_OUT_LATCH   = 8'h1C;
	localparam logic [7:0] ADR_EVT_STATUS  = 8'h20;
	localparam logic [7:0] ADR_EVT_MASK    = 8'h24;

	localparam int PORT_W = 6;

	// reset values
	localparam logic [7:0] RST_PULLUP_EN  = 8'h37;
	localparam logic [7:0] RST_CHANGE_EN  = 8'h00;
	localparam logic [7:0] RST_DIRECTION  = 8'h3F;
	localparam logic [7:0] RST_OPTION     = 8'hFF;
	localparam logic [7:0] RST_POWER_CTL  = 8'h00;
	localparam logic [7:0] RST_INT_CTL    = 8'h00;
	localparam logic [7:0] RST_OUT_LATCH  = 8'h00;
	localparam logic [7:0] RST_EVT        = 8'h00;

	// implemented-bit masks
	localparam logic [7:0] MASK_PULLUP    = 8'h37;
	localparam logic [7:0] MASK_PORT      = 8'h3F;
	localparam logic [7:0] MASK_XTAL_PINS = 8'h30;
	localparam logic [7:0] MASK_POWER     = 8'h20;
	localparam logic [7:0] MASK_INT_CTL   = 8'h81;
	localparam logic [7:0] MASK_OPTION    = 8'h80;
	localparam logic [7:0] MASK_EVT       = 8'h07;

	// field positions
	localparam int BIT_PULLUP_DIS   = 7;
	localparam int BIT_SLOW_WAKE_EN = 5;
	localparam int BIT_GLOB_INT_EN  = 7;
	localparam int BIT_CHANGE_FLAG  = 0;
	localparam int EVT_CHANGE       = 0;
	localparam int EVT_SLOW_FALL    = 1;
	localparam int EVT_WAKE         = 2;

	localparam logic [15:0] INT_VECTOR = 16'h0004;

	// oscillator modes from the configuration word
	typedef enum logic [2:0] {
		OSC_LOW_POWER_XTAL = 3'h0,
		OSC_MEDIUM_XTAL    = 3'h1,
		OSC_HIGH_SPEED_XTAL= 3'h2,
		OSC_EXT_CLOCK      = 3'h3,
		OSC_INT_RC         = 3'h4,
		OSC_INT_RC_CLKOUT  = 3'h5,
		OSC_EXT_RC         = 3'h6,
		OSC_EXT_RC_CLKOUT  = 3'h7
	} osc_mode_t;

	// classic wishbone request from the master
	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [7:0]  adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} wb_req_t;

endpackage : porta_pkg

// ---- logic/porta_wake.sv ----
// port a pull-up, change interrupt and slow-discharge wake logic
`timescale 1ns/1ns
`default_nettype none

module porta_wake
	import porta_pkg::*;
(
	// clock and reset
	input  wire logic                clk_in_unused_guard,
	input  wire logic                core_clk_in,
	input  wire logic                reset_n_in,
	// wishbone slave
	input  wire wb_req_t             wb_req_in,
	output logic                     wb_ack_out,
	output logic [31:0]              wb_dat_out,
	// port pins
	input  wire logic [PORT_W-1:0]   pin_level_in,
	output logic [PORT_W-1:0]        pin_drive_out,
	output logic [PORT_W-1:0]        pin_oe_out,
	output logic [PORT_W-1:0]        pullup_en_out,
	output logic                     pin0_sink_en_out,
	// core side
	input  wire osc_mode_t           osc_mode_in,
	input  wire logic                sleep_in,
	output logic                     wake_req_out,
	output logic                     core_irq_out,
	output logic [15:0]              branch_vector_out,
	output logic                     evt_irq_out
);

	// registers
	logic [7:0]        pullup_en_r;
	logic [7:0]        change_en_r;
	logic [7:0]        direction_r;
	logic [7:0]        option_r;
	logic [7:0]        power_ctl_r;
	logic [7:0]        int_ctl_r;
	logic [7:0]        out_latch_r;
	logic [7:0]        evt_status_r;
	logic [7:0]        evt_mask_r;
	logic              ack_r;
	logic [31:0]       rdat_r;
	logic [PORT_W-1:0] sync1_r;
	logic [PORT_W-1:0] sync2_r;
	logic [PORT_W-1:0] prev_r;
	logic [15:0]       vector_r;

	// decode
	wire        req_on     = wb_req_in.cyc & wb_req_in.stb;
	wire        wr_commit  = req_on & ack_r & wb_req_in.we & wb_req_in.sel[0];
	wire        rd_commit  = req_on & ack_r & ~wb_req_in.we;
	wire [7:0]  wdat       = wb_req_in.dat[7:0];
	wire [7:0]  adr        = wb_req_in.adr;
	wire        wr_pullup  = wr_commit & (adr == ADR_PULLUP_EN);
	wire        wr_change  = wr_commit & (adr == ADR_CHANGE_EN);
	wire        wr_dir     = wr_commit & (adr == ADR_DIRECTION);
	wire        wr_option  = wr_commit & (adr == ADR_OPTION);
	wire        wr_power   = wr_commit & (adr == ADR_POWER_CTL);
	wire        wr_intctl  = wr_commit & (adr == ADR_INT_CTL);
	wire        wr_latch   = wr_commit & (adr == ADR_OUT_LATCH);
	wire        wr_mask    = wr_commit & (adr == ADR_EVT_MASK);
	wire        rd_status  = rd_commit & (adr == ADR_EVT_STATUS);

	// crystal modes own pins 4 and 5, so those bits read as one
	wire        xtal_mode  = (osc_mode_in == OSC_LOW_POWER_XTAL) |
	                         (osc_mode_in == OSC_MEDIUM_XTAL) |
	                         (osc_mode_in == OSC_HIGH_SPEED_XTAL);
	wire [7:0]  xtal_force = xtal_mode ? MASK_XTAL_PINS : 8'h00;
	wire [7:0]  pullup_rd  = (pullup_en_r & MASK_PULLUP) | xtal_force;
	wire [7:0]  change_rd  = (change_en_r & MASK_PORT) | xtal_force;

	// change detection on synchronised pins
	wire [PORT_W-1:0] pin_diff   = sync2_r ^ prev_r;
	wire [PORT_W-1:0] change_hit = pin_diff & change_en_r[PORT_W-1:0];
	wire        change_evt = |change_hit;
	wire        slow_mode  = power_ctl_r[BIT_SLOW_WAKE_EN];
	wire        slow_fall  = slow_mode & prev_r[0] & ~sync2_r[0] &
	                         change_en_r[0];
	wire        change_flag = int_ctl_r[BIT_CHANGE_FLAG];
	wire        glob_int_en = int_ctl_r[BIT_GLOB_INT_EN];
	wire        wake_evt   = sleep_in & (change_flag | change_evt);

	// set wins over a software clear of the change flag
	wire [7:0]  intctl_wr  = wdat & MASK_INT_CTL;
	wire [7:0]  intctl_base = wr_intctl ? intctl_wr : int_ctl_r;
	wire [7:0]  int_ctl_nxt = {intctl_base[7:1],
	                          intctl_base[0] | change_evt};

	// sticky event status, read clears, new events win
	wire [7:0]  evt_set    = {5'h00, wake_evt, slow_fall, change_evt};
	// clear only what the read returned, so a late event is kept
	wire [7:0]  evt_base   = rd_status ? (evt_status_r & ~rdat_r[7:0])
	                                   : evt_status_r;
	wire [7:0]  evt_status_nxt = (evt_base | evt_set) & MASK_EVT;

	// read mux
	logic [7:0] rd_byte;
	always_comb
	begin
		case (adr)
			ADR_PULLUP_EN:  rd_byte = pullup_rd;
			ADR_CHANGE_EN:  rd_byte = change_rd;
			ADR_DIRECTION:  rd_byte = direction_r & MASK_PORT;
			ADR_OPTION:     rd_byte = option_r & MASK_OPTION;
			ADR_POWER_CTL:  rd_byte = power_ctl_r & MASK_POWER;
			ADR_INT_CTL:    rd_byte = int_ctl_r & MASK_INT_CTL;
			ADR_PIN_STATE:  rd_byte = {2'b00, sync2_r};
			ADR_OUT_LATCH:  rd_byte = out_latch_r & MASK_PORT;
			ADR_EVT_STATUS: rd_byte = evt_status_r;
			ADR_EVT_MASK:   rd_byte = evt_mask_r;
			default:        rd_byte = 8'h00;
		endcase
	end

	// bus handshake, answer one cycle after the request
	always_ff @(posedge core_clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			ack_r  <= 1'b0;
			rdat_r <= 32'h0000_0000;
		end
		else
		begin
			ack_r  <= req_on & ~ack_r;
			rdat_r <= {24'h00_0000, rd_byte};
		end
	end

	// software registers
	always_ff @(posedge core_clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			pullup_en_r <= RST_PULLUP_EN;
			change_en_r <= RST_CHANGE_EN;
			direction_r <= RST_DIRECTION;
			option_r    <= RST_OPTION;   // pull-ups off after reset
			power_ctl_r <= RST_POWER_CTL;
			out_latch_r <= RST_OUT_LATCH;
			evt_mask_r  <= RST_EVT;
		end
		else
		begin
			if (wr_pullup)
				pullup_en_r <= wdat & MASK_PULLUP;
			if (wr_change)
				change_en_r <= wdat & MASK_PORT;
			if (wr_dir)
				direction_r <= wdat & MASK_PORT;
			if (wr_option)
				option_r <= wdat | ~MASK_OPTION;
			if (wr_power)
				power_ctl_r <= wdat & MASK_POWER;
			if (wr_latch)
				out_latch_r <= wdat & MASK_PORT;
			if (wr_mask)
				evt_mask_r <= wdat & MASK_EVT;
		end
	end

	// flags and status
	always_ff @(posedge core_clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			int_ctl_r    <= RST_INT_CTL;
			evt_status_r <= RST_EVT;
			vector_r     <= 16'h0000;
		end
		else
		begin
			int_ctl_r    <= int_ctl_nxt;
			evt_status_r <= evt_status_nxt;
			vector_r     <= (glob_int_en & change_flag) ? INT_VECTOR
			                                            : 16'h0000;
		end
	end

	// two-stage pin synchroniser, then a history stage
	always_ff @(posedge core_clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			sync1_r <= '0;
			sync2_r <= '0;
			prev_r  <= '0;
		end
		else
		begin
			sync1_r <= pin_level_in;
			sync2_r <= sync1_r;
			prev_r  <= sync2_r;
		end
	end

	// pin and core outputs
	// sink only loads the pin while it is an input, so the charge phase
	// with pin 0 driven high does not fight the sink
	assign pin0_sink_en_out = slow_mode & direction_r[0];
	assign pin_drive_out    = out_latch_r[PORT_W-1:0];
	assign pin_oe_out       = ~direction_r[PORT_W-1:0];
	assign pullup_en_out    = pullup_en_r[PORT_W-1:0] &
	                          direction_r[PORT_W-1:0] &
	                          {PORT_W{~option_r[BIT_PULLUP_DIS]}};
	assign wake_req_out     = sleep_in & change_flag;
	assign core_irq_out     = glob_int_en & change_flag;
	assign branch_vector_out = vector_r;
	assign evt_irq_out      = |(evt_status_r & evt_mask_r);
	assign wb_ack_out       = ack_r;
	assign wb_dat_out       = rdat_r;

	// checks
	chk_change_read_zero: assert property (
		@(posedge core_clk_in) disable iff (!reset_n_in)
		(ack_r & ~wb_req_in.we & (wb_req_in.adr == ADR_CHANGE_EN))
		|-> (wb_dat_out[7:6] == 2'b00))
		else $error("change enable upper bits not zero");

	chk_irq_needs_global: assert property (
		@(posedge core_clk_in) disable iff (!reset_n_in)
		core_irq_out |-> (int_ctl_r[BIT_GLOB_INT_EN] &&
		                  int_ctl_r[BIT_CHANGE_FLAG]))
		else $error("core interrupt without global enable");

	chk_xtal_reads_one: assert property (
		@(posedge core_clk_in) disable iff (!reset_n_in)
		(req_on & ~ack_r & ~wb_req_in.we & xtal_mode &
		 ((adr == ADR_PULLUP_EN) | (adr == ADR_CHANGE_EN)))
		|=> (wb_dat_out[5:4] == 2'b11))
		else $error("crystal mode bits 5..4 not read as one");

	chk_sink_follows_enable: assert property (
		@(posedge core_clk_in) disable iff (!reset_n_in)
		(wr_power & wdat[BIT_SLOW_WAKE_EN] & direction_r[0])
		|=> pin0_sink_en_out)
		else $error("current sink not on after slow wake enable");

	chk_slow_fall_flags: assert property (
		@(posedge core_clk_in) disable iff (!reset_n_in)
		(slow_mode & change_en_r[0] & $fell(sync2_r[0]))
		|=> (int_ctl_r[BIT_CHANGE_FLAG] && evt_status_r[EVT_SLOW_FALL]))
		else $error("slow fall on pin 0 missed");

	chk_sleep_wake: assert property (
		@(posedge core_clk_in) disable iff (!reset_n_in)
		(sleep_in & change_evt) ##1 sleep_in |-> wake_req_out)
		else $error("no wake request after change in sleep");

	chk_vector_after_wake: assert property (
		@(posedge core_clk_in) disable iff (!reset_n_in)
		(glob_int_en & change_flag) |=> (branch_vector_out == INT_VECTOR))
		else $error("branch vector not presented");

	chk_global_pullup_off: assert property (
		@(posedge core_clk_in) disable iff (!reset_n_in)
		option_r[BIT_PULLUP_DIS] |-> (pullup_en_out == '0))
		else $error("pull-up on under global disable");

	chk_output_no_pullup: assert property (
		@(posedge core_clk_in) disable iff (!reset_n_in)
		(wr_dir & ~wdat[0]) |=> ##[0:2] !pullup_en_out[0])
		else $error("pull-up left on for output pin");

	chk_ack_one_cycle: assert property (
		@(posedge core_clk_in) disable iff (!reset_n_in)
		(req_on & ~ack_r) |=> ack_r ##1 !ack_r)
		else $error("bus answer not a single cycle");

	chk_pullup_read_mask: assert property (
		@(posedge core_clk_in) disable iff (!reset_n_in)
		(ack_r & ~wb_req_in.we & (wb_req_in.adr == ADR_PULLUP_EN))
		|-> ((wb_dat_out[7:0] & ~(MASK_PULLUP | MASK_XTAL_PINS)) == 8'h00))
		else $error("pull-up enable unimplemented bits not zero");

	chk_output_pin_no_pullup: assert property (
		@(posedge core_clk_in) disable iff (!reset_n_in)
		((pullup_en_out & pin_oe_out) == '0))
		else $error("pull-up on while pin drives");

	chk_change_write_mask: assert property (
		@(posedge core_clk_in) disable iff (!reset_n_in)
		wr_change |=> ((change_en_r & ~MASK_PORT) == 8'h00))
		else $error("change enable kept unimplemented bits");

	chk_change_sets_flag: assert property (
		@(posedge core_clk_in) disable iff (!reset_n_in)
		change_evt |=> int_ctl_r[BIT_CHANGE_FLAG])
		else $error("change event did not set the flag");

	chk_irq_on_flag: assert property (
		@(posedge core_clk_in) disable iff (!reset_n_in)
		(glob_int_en & change_flag) |-> core_irq_out)
		else $error("core interrupt missing with global enable");

	chk_sink_off_output: assert property (
		@(posedge core_clk_in) disable iff (!reset_n_in)
		pin_oe_out[0] |-> !pin0_sink_en_out)
		else $error("current sink on while pin 0 drives");

	chk_sink_off_idle: assert property (
		@(posedge core_clk_in) disable iff (!reset_n_in)
		!slow_mode |-> !pin0_sink_en_out)
		else $error("current sink on without slow wake");

	chk_wake_needs_sleep: assert property (
		@(posedge core_clk_in) disable iff (!reset_n_in)
		wake_req_out |-> sleep_in)
		else $error("wake request while awake");

	chk_status_read_clear: assert property (
		@(posedge core_clk_in) disable iff (!reset_n_in)
		(rd_status & ~(|evt_set))
		|=> ((evt_status_r & $past(rdat_r[7:0])) == 8'h00))
		else $error("event status not cleared by read");

	chk_event_sticky: assert property (
		@(posedge core_clk_in) disable iff (!reset_n_in)
		(|evt_set)
		|=> ((evt_status_r & $past(evt_set)) == $past(evt_set)))
		else $error("event lost from status");

	chk_vector_idle: assert property (
		@(posedge core_clk_in) disable iff (!reset_n_in)
		!(glob_int_en & change_flag) |=> (branch_vector_out == 16'h0000))
		else $error("branch vector without interrupt");

	chk_read_high_zero: assert property (
		@(posedge core_clk_in) disable iff (!reset_n_in)
		ack_r |-> (wb_dat_out[31:8] == 24'h00_0000))
		else $error("read data upper bits not zero");

	chk_ack_needs_req: assert property (
		@(posedge core_clk_in) disable iff (!reset_n_in)
		ack_r |-> $past(req_on))
		else $error("bus answer without request");

	chk_write_lands: assert property (
		@(posedge core_clk_in) disable iff (!reset_n_in)
		wr_dir |=> (direction_r == ($past(wdat) & MASK_PORT)))
		else $error("direction write not stored");

endmodule : porta_wake

`default_nettype wire

// ---- testbench/porta_wake_test.sv ----
// self-checking bench for the port a pull-up, change and wake block
`timescale 1ns/1ns
`default_nettype none
module porta_wake_test
	import porta_pkg::*;
;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        sleep = 1'b0;
	wb_req_t     req = '0;
	osc_mode_t   osc = OSC_INT_RC;
	logic        ack, sink, wake, irq, evt, lvl0;
	logic [31:0] rdata, q, v;
	logic [5:0]  drv, oe, pu, lvl;
	logic [15:0] vec;
	logic [31:0] seed = 32'h0000_89DD;
	int          err_total = 0;
	int          tests_run = 0;

	// pins 5..1: driven, else pulled up, else low
	assign lvl = {(drv[5:1] & oe[5:1]) | (pu[5:1] & ~oe[5:1]), lvl0};

	porta_wake dut_u (.clk_in_unused_guard(1'b0), .core_clk_in(clk),
		.reset_n_in(rst_n), .wb_req_in(req), .wb_ack_out(ack),
		.wb_dat_out(rdata), .pin_level_in(lvl), .pin_drive_out(drv),
		.pin_oe_out(oe), .pullup_en_out(pu), .pin0_sink_en_out(sink),
		.osc_mode_in(osc), .sleep_in(sleep), .wake_req_out(wake),
		.core_irq_out(irq), .branch_vector_out(vec), .evt_irq_out(evt));

	rc_pin0_model rc_u (.core_clk_in(clk), .drive_in(drv[0]),
		.oe_in(oe[0]), .sink_in(sink), .level_out(lvl0));

	function automatic logic [31:0] next_rand();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : next_rand

	function automatic logic [31:0] exp_en(logic [7:0] d, logic [7:0] m,
		osc_mode_t o);
		return {24'h0, (d & m) | (o <= OSC_HIGH_SPEED_XTAL ? 8'h30 : 8'h00)};
	endfunction : exp_en

	task close_out;
		$display("checks %0d errors %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : close_out

	task chk(input logic [31:0] seen, input logic [31:0] want);
		tests_run++;
		if (seen !== want)
		begin
			err_total++;
			$display("wrong value at %0t: %0h vs %0h", $time, seen, want);
		end
	endtask : chk

	// one classic cycle; held until ack is sampled high
	task wb(input logic we, input logic [7:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk);
		req <= '{1'b1, 1'b1, we, a, 4'hF, {24'h0, d}};
		do
		begin
			@(posedge clk);
			n++;
		end
		while (ack !== 1'b1 && n < 20);
		q = rdata;
		req <= '0;
		if (ack !== 1'b1)
		begin
			err_total++;
			close_out();
		end
	endtask : wb

	initial
		forever #5 clk = ~clk;

	initial
	begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		@(negedge clk);
		chk(pu, 6'h00);
		wb(1'b0, ADR_CHANGE_EN, 8'h00);
		chk(q, 32'h0);
		wb(1'b0, 8'h3C, 8'h00);
		chk(q, 32'h0);
		for (int m = 0; m < 8; m++)
		begin
			osc <= osc_mode_t'(m);
			v = next_rand();
			wb(1'b1, ADR_CHANGE_EN, v[7:0]);
			wb(1'b0, ADR_CHANGE_EN, 8'h00);
			chk(q, exp_en(v[7:0], MASK_PORT, osc));
			wb(1'b1, ADR_PULLUP_EN, v[15:8]);
			wb(1'b0, ADR_PULLUP_EN, 8'h00);
			chk(q, exp_en(v[15:8], MASK_PULLUP, osc));
		end
		osc <= OSC_INT_RC;
		wb(1'b1, ADR_CHANGE_EN, 8'h00);
		wb(1'b1, ADR_PULLUP_EN, 8'h37);
		wb(1'b1, ADR_OPTION, 8'h00);
		wb(1'b1, ADR_DIRECTION, 8'h3D);
		@(negedge clk);
		chk(pu, 6'h35);
		chk(oe, 6'h02);
		chk(drv, 6'h00);
		wb(1'b1, ADR_OPTION, 8'h80);
		@(negedge clk);
		chk(pu, 6'h00);
		wb(1'b1, ADR_EVT_MASK, 8'h07);
		for (int g = 0; g < 2; g++)
		begin
			// charge, release, arm, slow wake on, sleep
			wb(1'b1, ADR_CHANGE_EN, 8'h00);
			wb(1'b1, ADR_OUT_LATCH, 8'h01);
			wb(1'b1, ADR_DIRECTION, 8'h3E);
			@(negedge clk);
			chk(oe, 6'h01);
			chk(drv, 6'h01);
			wb(1'b1, ADR_DIRECTION, 8'h3F);
			wb(1'b0, ADR_PIN_STATE, 8'h00);
			chk(q, 32'h01);
			wb(1'b1, ADR_CHANGE_EN, 8'h01);
			wb(1'b1, ADR_INT_CTL, g[0] ? 8'h80 : 8'h00);
			wb(1'b1, ADR_POWER_CTL, 8'h20);
			@(negedge clk);
			chk(sink, 1'b1);
			@(posedge clk);
			sleep <= 1'b1;
			for (int n = 0; n < 300 && wake !== 1'b1; n++)
				@(negedge clk);
			chk(wake, 1'b1);
			chk(irq, g[0]);
			@(negedge clk);
			chk(vec, g[0] ? 16'h0004 : 16'h0000);
			chk(evt, !g[0]);
			@(posedge clk);
			sleep <= 1'b0;
			wb(1'b0, ADR_INT_CTL, 8'h00);
			chk(q, g[0] ? 32'h81 : 32'h01);
			wb(1'b0, ADR_EVT_STATUS, 8'h00);
			chk(q, 32'h07);
			@(negedge clk);
			chk(evt, 1'b0);
			wb(1'b1, ADR_EVT_MASK, 8'h00);
			wb(1'b1, ADR_POWER_CTL, 8'h00);
		end
		// reset in mid-run: registers back to power-on values
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(negedge clk);
		chk(pu, 6'h00);
		chk(oe, 6'h00);
		chk(sink, 1'b0);
		wb(1'b0, ADR_OPTION, 8'h00);
		chk(q, 32'h80);
		wb(1'b0, ADR_PULLUP_EN, 8'h00);
		chk(q, 32'h37);
		wb(1'b0, ADR_DIRECTION, 8'h00);
		chk(q, 32'h3F);
		wb(1'b0, ADR_INT_CTL, 8'h00);
		chk(q, 32'h00);
		close_out();
	end
endmodule : porta_wake_test
`default_nettype wire

// ---- testbench/rc_pin0_model.sv ----
// external rc network hanging on port pin zero
`timescale 1ns/1ns
`default_nettype none
module rc_pin0_model
#(
	parameter int HOLD_CYC = 40
)
(
	// clock
	input  wire logic core_clk_in,
	// pin side
	input  wire logic drive_in,
	input  wire logic oe_in,
	input  wire logic sink_in,
	output logic      level_out
);
	int charge_r = 0;
	// driver charges the cap, the sink bleeds it slowly
	always @(posedge core_clk_in)
	begin
		if (oe_in)
			charge_r <= drive_in ? HOLD_CYC : 0;
		else if (sink_in && charge_r != 0)
			charge_r <= charge_r - 1;
	end
	// no sink: a real cap keeps its charge, so the level stays
	assign level_out = oe_in ? drive_in : (charge_r != 0);
endmodule : rc_pin0_model
`default_nettype wire
